// ---- src/mid_pkg.sv ----
/*
 package for the extended move instruction decoder: escape prefix,
 opcode and form nibbles, state counts and the decoded command layout.
 assumes the core fetch path hands over one instruction byte at a time.
*/
`default_nettype none
package mid_pkg;
	// escape prefix that opens an extended opcode in binary mode
	localparam logic [7:0] ESC_PREFIX  = 8'ha5;
	// extended move opcode bytes
	localparam logic [7:0] OPC_LOAD    = 8'h7e;
	localparam logic [7:0] OPC_STORE   = 8'h7a;
	localparam logic [7:0] OPC_B_WDISP = 8'h09;
	localparam logic [7:0] OPC_W_WDISP = 8'h49;
	localparam logic [7:0] OPC_B_DDISP = 8'h29;
	localparam logic [7:0] OPC_W_DDISP = 8'h69;
	// low nibble of the field byte that picks the form
	localparam logic [3:0] NIB_B_DIRECT_ADDRESS_8  = 4'h1;
	localparam logic [3:0] NIB_W_DIRECT_ADDRESS_8  = 4'h5;
	localparam logic [3:0] NIB_D_DIRECT_ADDRESS_8  = 4'hd;
	localparam logic [3:0] NIB_B_DIRECT_ADDRESS_16 = 4'h3;
	localparam logic [3:0] NIB_W_DIRECT_ADDRESS_16 = 4'h7;
	localparam logic [3:0] NIB_D_DIRECT_ADDRESS_16 = 4'hf;
	localparam logic [3:0] NIB_B_ATD   = 4'hb;
	localparam logic [3:0] NIB_ZERO    = 4'h0;
	// binary mode state counts per form
	localparam logic [3:0] ST_B_DIRECT_ADDRESS_8   = 4'h3;
	localparam logic [3:0] ST_W_DIRECT_ADDRESS_8   = 4'h4;
	localparam logic [3:0] ST_D_DIRECT_ADDRESS_8   = 4'h6;
	localparam logic [3:0] ST_B_DIRECT_ADDRESS_16  = 4'h3;
	localparam logic [3:0] ST_W_DIRECT_ADDRESS_16  = 4'h4;
	localparam logic [3:0] ST_D_DIRECT_ADDRESS_16  = 4'h6;
	localparam logic [3:0] ST_B_ATD    = 4'h4;
	localparam logic [3:0] ST_SB_DIRECT_ADDRESS_16 = 4'h4;
	localparam logic [3:0] ST_SW_DIRECT_ADDRESS_16 = 4'h5;
	localparam logic [3:0] ST_SD_DIRECT_ADDRESS_16 = 4'h7;
	localparam logic [3:0] ST_B_WDISP  = 4'h6;
	localparam logic [3:0] ST_W_WDISP  = 4'h7;
	localparam logic [3:0] ST_B_DDISP  = 4'h7;
	localparam logic [3:0] ST_W_DDISP  = 4'h8;
	// source mode drops the prefix state; port access by OP_LD_B_DIRECT_ADDRESS_8 adds one
	localparam logic [3:0] SRC_SAVING  = 4'h1;
	localparam logic [3:0] PORT_EXTRA  = 4'h1;
	localparam logic [3:0] CNT_LAST    = 4'h1;
	// operand byte counts after the field byte
	localparam logic [1:0] LEN_ONE     = 2'h1;
	localparam logic [1:0] LEN_TWO     = 2'h2;
	// direct addresses of the four io port registers (plain defaults)
	localparam int         PORT_COUNT  = 4;
	localparam logic [7:0] PORT_ADDR [PORT_COUNT] = '{8'h80, 8'h90, 8'ha0, 8'hb0};

	// decoded operation
	typedef enum logic [3:0] {
		OP_NONE, OP_LD_B_DIRECT_ADDRESS_8, OP_LD_W_DIRECT_ADDRESS_8, OP_LD_D_DIRECT_ADDRESS_8,
		OP_LD_B_DIRECT_ADDRESS_16, OP_LD_W_DIRECT_ADDRESS_16, OP_LD_D_DIRECT_ADDRESS_16, OP_LD_B_ATD,
		OP_ST_B_DIRECT_ADDRESS_16, OP_ST_W_DIRECT_ADDRESS_16, OP_ST_D_DIRECT_ADDRESS_16,
		OP_LD_B_WDISP, OP_LD_W_WDISP, OP_LD_B_DDISP, OP_LD_W_DDISP
	} mid_op_t;

	// operand width
	typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_DWORD} mid_size_t;

	// result of classifying opcode plus field byte
	typedef struct packed {
		mid_op_t   op;       // operation
		mid_size_t size;     // operand width
		logic      store;    // register to memory
		logic      has_ptr;  // field names a pointer: low nibble, or high nibble with reg_late
		logic      reg_late; // register nibble comes in the third byte
		logic [1:0] nbytes;  // operand bytes still to fetch
		logic [3:0] states;  // binary mode state count
	} mid_form_t;

	// command handed to the core execute path
	typedef struct packed {
		mid_op_t    op;      // operation
		mid_size_t  size;    // operand width
		logic       store;   // register to memory
		logic [3:0] reg_sel; // data register number
		logic [3:0] ptr_sel; // pointer register number
		logic [23:0] addr;   // direct address or displacement
		logic [3:0] states;  // execute states
	} mid_cmd_t;
endpackage
`default_nettype wire

// ---- src/mid_form_decode.sv ----
/*
 combinational classifier: opcode byte plus field byte to form.
 assumes both bytes are stable while the caller samples the result.
*/
`timescale 1ns/1ps
`default_nettype none
module mid_form_decode
(
	input  wire logic [7:0]       opcode, // extended opcode
	input  wire logic [7:0]       field,  // second byte
	output var  mid_pkg::mid_form_t form  // classification
);
	////////////////////////////////////////////////////////////////////
	// form table
	always_comb
	begin
		form = '{op: mid_pkg::OP_NONE, size: mid_pkg::SZ_BYTE, store: 1'b0,
			has_ptr: 1'b0, reg_late: 1'b0, nbytes: mid_pkg::LEN_TWO, states: '0};
		unique case (opcode)
			mid_pkg::OPC_LOAD:
			begin
				// register nibble high (pointer nibble for NIB_B_ATD), form nibble low
				unique case (field[3:0])
					mid_pkg::NIB_B_DIRECT_ADDRESS_8:
						form = '{mid_pkg::OP_LD_B_DIRECT_ADDRESS_8, mid_pkg::SZ_BYTE, 1'b0, 1'b0, 1'b0,
							mid_pkg::LEN_ONE, mid_pkg::ST_B_DIRECT_ADDRESS_8};
					mid_pkg::NIB_W_DIRECT_ADDRESS_8:
						form = '{mid_pkg::OP_LD_W_DIRECT_ADDRESS_8, mid_pkg::SZ_WORD, 1'b0, 1'b0, 1'b0,
							mid_pkg::LEN_ONE, mid_pkg::ST_W_DIRECT_ADDRESS_8};
					mid_pkg::NIB_D_DIRECT_ADDRESS_8:
						form = '{mid_pkg::OP_LD_D_DIRECT_ADDRESS_8, mid_pkg::SZ_DWORD, 1'b0, 1'b0, 1'b0,
							mid_pkg::LEN_ONE, mid_pkg::ST_D_DIRECT_ADDRESS_8};
					mid_pkg::NIB_B_DIRECT_ADDRESS_16:
						form = '{mid_pkg::OP_LD_B_DIRECT_ADDRESS_16, mid_pkg::SZ_BYTE, 1'b0, 1'b0, 1'b0,
							mid_pkg::LEN_TWO, mid_pkg::ST_B_DIRECT_ADDRESS_16};
					mid_pkg::NIB_W_DIRECT_ADDRESS_16:
						form = '{mid_pkg::OP_LD_W_DIRECT_ADDRESS_16, mid_pkg::SZ_WORD, 1'b0, 1'b0, 1'b0,
							mid_pkg::LEN_TWO, mid_pkg::ST_W_DIRECT_ADDRESS_16};
					mid_pkg::NIB_D_DIRECT_ADDRESS_16:
						form = '{mid_pkg::OP_LD_D_DIRECT_ADDRESS_16, mid_pkg::SZ_DWORD, 1'b0, 1'b0, 1'b0,
							mid_pkg::LEN_TWO, mid_pkg::ST_D_DIRECT_ADDRESS_16};
					mid_pkg::NIB_B_ATD:
						form = '{mid_pkg::OP_LD_B_ATD, mid_pkg::SZ_BYTE, 1'b0, 1'b1, 1'b1,
							mid_pkg::LEN_ONE, mid_pkg::ST_B_ATD};
					default: ;
				endcase
			end
			mid_pkg::OPC_STORE:
			begin
				unique case (field[3:0])
					mid_pkg::NIB_B_DIRECT_ADDRESS_16:
						form = '{mid_pkg::OP_ST_B_DIRECT_ADDRESS_16, mid_pkg::SZ_BYTE, 1'b1, 1'b0, 1'b0,
							mid_pkg::LEN_TWO, mid_pkg::ST_SB_DIRECT_ADDRESS_16};
					mid_pkg::NIB_W_DIRECT_ADDRESS_16:
						form = '{mid_pkg::OP_ST_W_DIRECT_ADDRESS_16, mid_pkg::SZ_WORD, 1'b1, 1'b0, 1'b0,
							mid_pkg::LEN_TWO, mid_pkg::ST_SW_DIRECT_ADDRESS_16};
					mid_pkg::NIB_D_DIRECT_ADDRESS_16:
						form = '{mid_pkg::OP_ST_D_DIRECT_ADDRESS_16, mid_pkg::SZ_DWORD, 1'b1, 1'b0, 1'b0,
							mid_pkg::LEN_TWO, mid_pkg::ST_SD_DIRECT_ADDRESS_16};
					default: ;
				endcase
			end
			// displacement forms: data register high, pointer low
			mid_pkg::OPC_B_WDISP:
				form = '{mid_pkg::OP_LD_B_WDISP, mid_pkg::SZ_BYTE, 1'b0, 1'b1, 1'b0,
					mid_pkg::LEN_TWO, mid_pkg::ST_B_WDISP};
			mid_pkg::OPC_W_WDISP:
				form = '{mid_pkg::OP_LD_W_WDISP, mid_pkg::SZ_WORD, 1'b0, 1'b1, 1'b0,
					mid_pkg::LEN_TWO, mid_pkg::ST_W_WDISP};
			mid_pkg::OPC_B_DDISP:
				form = '{mid_pkg::OP_LD_B_DDISP, mid_pkg::SZ_BYTE, 1'b0, 1'b1, 1'b0,
					mid_pkg::LEN_TWO, mid_pkg::ST_B_DDISP};
			mid_pkg::OPC_W_DDISP:
				form = '{mid_pkg::OP_LD_W_DDISP, mid_pkg::SZ_WORD, 1'b0, 1'b1, 1'b0,
					mid_pkg::LEN_TWO, mid_pkg::ST_W_DDISP};
			default: ;
		endcase
	end
endmodule // mid_form_decode
`default_nettype wire

// ---- src/mid_move_decoder.sv ----
/*
 extended move instruction decoder: takes instruction bytes, strips the
 escape prefix in binary mode, collects fields and operands, holds for the
 execute states and then issues one decoded command.
 assumes fetch bytes and the mode input come from logic on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module mid_move_decoder
(
	input  wire logic               ref_clk,     // core clock, 10 MHz
	input  wire logic               rst_b,       // async reset, active low
	input  wire logic               src_mode,    // 1 = source mode
	input  wire logic               fetch_valid, // byte offered
	input  wire logic [7:0]         fetch_byte,  // instruction byte
	output logic                    fetch_ready, // byte accepted when high
	output logic                    busy,        // instruction in progress
	output logic                    cmd_valid,   // one-cycle command pulse
	output var mid_pkg::mid_cmd_t   cmd,         // decoded command
	output logic                    not_ours     // one-cycle reject pulse
);
	////////////////////////////////////////////////////////////////////
	// reset release
	logic rst_q1;  // first release stage
	logic rst_n;   // synchronised reset, active low

	// release through two stages, assert at once
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rst_q1 <= 1'b0;
			rst_n  <= 1'b0;
		end
		else
		begin
			rst_q1 <= 1'b1;
			rst_n  <= rst_q1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// decode helpers
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000, // wait for prefix or opcode
		ST_OPC   = 3'b001, // prefix seen, wait for opcode
		ST_FIELD = 3'b011, // wait for register/form byte
		ST_OPND  = 3'b010, // collect operand bytes
		ST_EXEC  = 3'b110  // count execute states
	} mid_state_t;

	// true for an io port register address
	function automatic logic is_port(input logic [7:0] a);
		is_port = 1'b0;
		for (int i = 0; i < mid_pkg::PORT_COUNT; i++)
			if (a == mid_pkg::PORT_ADDR[i])
				is_port = 1'b1;
	endfunction

	// true for an extended move opcode
	function automatic logic is_ext(input logic [7:0] b);
		is_ext = (b == mid_pkg::OPC_LOAD) || (b == mid_pkg::OPC_STORE) ||
			(b == mid_pkg::OPC_B_WDISP) || (b == mid_pkg::OPC_W_WDISP) ||
			(b == mid_pkg::OPC_B_DDISP) || (b == mid_pkg::OPC_W_DDISP);
	endfunction

	mid_state_t         state, next_state;       // sequencer
	logic [7:0]         opc, next_opc;           // latched opcode
	logic               mode_q, next_mode;       // mode for this instruction
	logic [1:0]         left, next_left;         // operand bytes to go
	logic [3:0]         cnt, next_cnt;           // execute states to go
	logic               late, next_late;         // register in third byte
	mid_pkg::mid_cmd_t  next_cmd;                // command under build
	logic               next_valid, next_rej;    // output pulses
	logic               next_ready, next_busy;   // output levels
	mid_pkg::mid_form_t form;                    // classifier result
	logic               take;                    // byte handshake

	assign take = fetch_valid && fetch_ready;

	// classify opcode with the byte on the fetch port
	mid_form_decode u_form
	(
		.opcode (opc),
		.field  (fetch_byte),
		.form   (form)
	);

	////////////////////////////////////////////////////////////////////
	// sequencer next state
	always_comb
	begin
		next_state = state;
		next_opc   = opc;
		next_mode  = mode_q;
		next_left  = left;
		next_cnt   = cnt;
		next_late  = late;
		next_cmd   = cmd;
		next_valid = 1'b0;
		next_rej   = 1'b0;
		unique case (state)
			ST_IDLE:
			if (take)
			begin
				next_mode = src_mode;
				if (src_mode)
				begin
					// opcode stands first, no prefix
					if (is_ext(fetch_byte))
					begin
						next_opc   = fetch_byte;
						next_state = ST_FIELD;
					end
					else
						next_rej = 1'b1;
				end
				else if (fetch_byte == mid_pkg::ESC_PREFIX)
					next_state = ST_OPC;
				else
					next_rej = 1'b1;
			end
			ST_OPC:
			if (take)
			begin
				// opcode after the prefix
				if (is_ext(fetch_byte))
				begin
					next_opc   = fetch_byte;
					next_state = ST_FIELD;
				end
				else
				begin
					next_rej   = 1'b1;
					next_state = ST_IDLE;
				end
			end
			ST_FIELD:
			if (take)
			begin
				if (form.op == mid_pkg::OP_NONE)
				begin
					// unknown form nibble
					next_rej   = 1'b1;
					next_state = ST_IDLE;
				end
				else
				begin
					// register nibbles: data high and pointer low, or pointer high and data late
					next_cmd.op      = form.op;
					next_cmd.size    = form.size;
					next_cmd.store   = form.store;
					next_cmd.reg_sel = form.reg_late ? '0 : fetch_byte[7:4];
					next_cmd.ptr_sel = form.reg_late ? fetch_byte[7:4] :
						(form.has_ptr ? fetch_byte[3:0] : '0);
					next_cmd.addr    = '0;
					next_cmd.states  = form.states -
						(mode_q ? mid_pkg::SRC_SAVING : '0);
					next_left  = form.nbytes;
					next_late  = form.reg_late;
					next_state = ST_OPND;
				end
			end
			ST_OPND:
			if (take)
			begin
				next_left = left - 2'h1;
				if (late && (fetch_byte[3:0] != mid_pkg::NIB_ZERO))
				begin
					// third byte of the pointer form must end in zero
					next_rej   = 1'b1;
					next_state = ST_IDLE;
				end
				else
				begin
					if (late)
						next_cmd.reg_sel = fetch_byte[7:4];
					else
						next_cmd.addr = {cmd.addr[15:0], fetch_byte};
					if (left == mid_pkg::LEN_ONE)
					begin
						// last operand byte: load the state count
						next_cnt = cmd.states;
						if ((cmd.op == mid_pkg::OP_LD_B_DIRECT_ADDRESS_8) && is_port(fetch_byte))
						begin
							// port access: the reported count carries the extra state too
							next_cnt        = cmd.states + mid_pkg::PORT_EXTRA;
							next_cmd.states = cmd.states + mid_pkg::PORT_EXTRA;
						end
						next_state = ST_EXEC;
					end
				end
			end
			ST_EXEC:
			begin
				// one cycle per execute state
				next_cnt = cnt - 4'h1;
				if (cnt == mid_pkg::CNT_LAST)
				begin
					next_valid = 1'b1;
					next_state = ST_IDLE;
				end
			end
			default:
				next_state = ST_IDLE;
		endcase
		next_ready = (next_state != ST_EXEC);
		next_busy  = (next_state != ST_IDLE);
	end

	////////////////////////////////////////////////////////////////////
	// sequencer registers
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state       <= ST_IDLE;
			opc         <= '0;
			mode_q      <= 1'b0;
			left        <= '0;
			cnt         <= '0;
			late        <= 1'b0;
			cmd         <= '0;
			cmd_valid   <= 1'b0;
			not_ours    <= 1'b0;
			fetch_ready <= 1'b0;
			busy        <= 1'b0;
		end
		else
		begin
			state       <= next_state;
			opc         <= next_opc;
			mode_q      <= next_mode;
			left        <= next_left;
			cnt         <= next_cnt;
			late        <= next_late;
			cmd         <= next_cmd;
			cmd_valid   <= next_valid;
			not_ours    <= next_rej;
			fetch_ready <= next_ready;
			busy        <= next_busy;
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// execute phase of a given length then the command pulse
	sequence s_exec7;
		(state == ST_EXEC) [*7] ##1 cmd_valid;
	endsequence
	sequence s_exec6;
		(state == ST_EXEC) [*6] ##1 cmd_valid;
	endsequence

	property p_bin_prefix;
		(state == ST_IDLE) && take && !src_mode && (fetch_byte != mid_pkg::ESC_PREFIX)
		|=> not_ours && (state == ST_IDLE);
	endproperty
	a_bin_prefix: assert property (p_bin_prefix) else $error("opcode without prefix taken");

	property p_src_direct;
		(state == ST_IDLE) && take && src_mode && (fetch_byte == mid_pkg::OPC_LOAD)
		|=> (state == ST_FIELD) && (opc == mid_pkg::OPC_LOAD);
	endproperty
	a_src_direct: assert property (p_src_direct) else $error("source opcode not accepted");

	property p_port_extra;
		(state == ST_OPND) && take && (cmd.op == mid_pkg::OP_LD_B_DIRECT_ADDRESS_8) && is_port(fetch_byte)
		|=> (state == ST_EXEC) && (cnt == $past(cmd.states) + mid_pkg::PORT_EXTRA);
	endproperty
	a_port_extra: assert property (p_port_extra) else $error("port state missing");

	property p_ld_b_direct_address_16;
		(state == ST_FIELD) && take && (opc == mid_pkg::OPC_LOAD) &&
		(fetch_byte[3:0] == mid_pkg::NIB_B_DIRECT_ADDRESS_16)
		|=> (cmd.op == mid_pkg::OP_LD_B_DIRECT_ADDRESS_16) && (cmd.reg_sel == $past(fetch_byte[7:4]));
	endproperty
	a_ld_b_direct_address_16: assert property (p_ld_b_direct_address_16) else $error("byte direct_address_16 load misdecoded");

	property p_ld_w_direct_address_16;
		(state == ST_FIELD) && take && (opc == mid_pkg::OPC_LOAD) &&
		(fetch_byte[3:0] == mid_pkg::NIB_W_DIRECT_ADDRESS_16)
		|=> (cmd.op == mid_pkg::OP_LD_W_DIRECT_ADDRESS_16) && (left == mid_pkg::LEN_TWO);
	endproperty
	a_ld_w_direct_address_16: assert property (p_ld_w_direct_address_16) else $error("word direct_address_16 load misdecoded");

	property p_st_d_direct_address_16;
		(state == ST_FIELD) && take && (opc == mid_pkg::OPC_STORE) &&
		(fetch_byte[3:0] == mid_pkg::NIB_D_DIRECT_ADDRESS_16)
		|=> (cmd.op == mid_pkg::OP_ST_D_DIRECT_ADDRESS_16) && cmd.store && (cmd.size == mid_pkg::SZ_DWORD);
	endproperty
	a_st_d_direct_address_16: assert property (p_st_d_direct_address_16) else $error("dword store misdecoded");

	property p_disp_order;
		(state == ST_OPND) && take && !late && (left == mid_pkg::LEN_ONE)
		|=> (cmd.addr[7:0] == $past(fetch_byte)) && (cmd.addr[15:8] == $past(cmd.addr[7:0]));
	endproperty
	a_disp_order: assert property (p_disp_order) else $error("displacement byte order");

	property p_wdisp_bin;
		$rose(state == ST_EXEC) && (cmd.op == mid_pkg::OP_LD_W_WDISP) && !mode_q |-> s_exec7;
	endproperty
	a_wdisp_bin: assert property (p_wdisp_bin) else $error("word disp load not 7 states");

	property p_wdisp_src;
		$rose(state == ST_EXEC) && (cmd.op == mid_pkg::OP_LD_W_WDISP) && mode_q |-> s_exec6;
	endproperty
	a_wdisp_src: assert property (p_wdisp_src) else $error("word disp load not 6 states");

	property p_ddisp_bin;
		$rose(state == ST_EXEC) && (cmd.op == mid_pkg::OP_LD_B_DDISP) && !mode_q |-> s_exec7;
	endproperty
	a_ddisp_bin: assert property (p_ddisp_bin) else $error("byte dword disp not 7 states");
endmodule // mid_move_decoder
`default_nettype wire

// ---- bench/mid_fetch_model.sv ----
/*
 fetch path model: offers queued instruction bytes to the decoder,
 stalling at random between bytes.
 assumes ref_clk from the bench; bytes are queued through push.
*/
`timescale 1ns/1ps
`default_nettype none
module mid_fetch_model
(
	input  wire logic       ref_clk,     // core clock
	input  wire logic       fetch_ready, // decoder takes a byte
	output logic            fetch_valid, // byte offered
	output logic [7:0]      fetch_byte   // offered byte
);
	logic [7:0] pend [$]; // bytes still to offer
	logic       taken;    // byte taken at this edge

	// queue one byte for offering
	task automatic push(input logic [7:0] b);
		pend.push_back(b);
	endtask

	////////////////////////////////////////////////////////////////////////
	// offer bytes, hold each until taken, scramble the line when idle
	initial
	begin
		fetch_valid = 1'b0;
		fetch_byte  = 8'h00;
		forever
		begin
			@(posedge ref_clk);
			taken = fetch_valid && fetch_ready;
			#5;
			if (taken)
				void'(pend.pop_front());
			if (fetch_valid && !taken)
				fetch_valid = 1'b1;
			else if (pend.size() != 0 && $urandom % 4 != 0)
			begin
				fetch_valid = 1'b1;
				fetch_byte  = pend[0];
			end
			else
			begin
				// stall: no stale byte left on the line
				fetch_valid = 1'b0;
				fetch_byte  = ~fetch_byte;
			end
		end
	end
endmodule // mid_fetch_model
`default_nettype wire

// ---- bench/tb_move_instruction_decoder.sv ----
/*
 self-checking bench for the extended move decoder: sends each form in
 both modes, notes the expected command and timing, compares on output.
 assumes mid_pkg and the fetch model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_move_instruction_decoder;
	// one expected result
	typedef struct {
		logic              rej; // reject expected
		logic              ca;  // compare address
		mid_pkg::mid_op_t  op;
		logic [3:0]        rs;
		logic [3:0]        ps;
		logic [23:0]       ad;
		logic [3:0]        st;
	} mid_note_t;

	// form table: opcode, nibble, kind, states in binary mode, operation
	localparam logic [7:0] OPC [15] = '{8'h7e, 8'h7e, 8'h7e, 8'h7a, 8'h7a, 8'h7e,
		8'h49, 8'h29, 8'h69, 8'h7e, 8'h7e, 8'h09, 8'h7e, 8'h7e, 8'h7a};
	localparam logic [3:0] NIB [15] = '{4'h3, 4'h7, 4'hf, 4'hf, 4'h7, 4'hb,
		4'h0, 4'h0, 4'h0, 4'h1, 4'h1, 4'h0, 4'h5, 4'hd, 4'h3};
	localparam logic [1:0] KND [15] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1,
		2'h2, 2'h2, 2'h2, 2'h3, 2'h3, 2'h2, 2'h3, 2'h3, 2'h0};
	localparam logic [3:0] BST [15] = '{4'h3, 4'h4, 4'h6, 4'h7, 4'h5, 4'h4,
		4'h7, 4'h7, 4'h8, 4'h4, 4'h3, 4'h6, 4'h4, 4'h6, 4'h4};
	localparam mid_pkg::mid_op_t OPS [15] = '{mid_pkg::OP_LD_B_DIRECT_ADDRESS_16,
		mid_pkg::OP_LD_W_DIRECT_ADDRESS_16, mid_pkg::OP_LD_D_DIRECT_ADDRESS_16, mid_pkg::OP_ST_D_DIRECT_ADDRESS_16,
		mid_pkg::OP_ST_W_DIRECT_ADDRESS_16, mid_pkg::OP_LD_B_ATD, mid_pkg::OP_LD_W_WDISP,
		mid_pkg::OP_LD_B_DDISP, mid_pkg::OP_LD_W_DDISP, mid_pkg::OP_LD_B_DIRECT_ADDRESS_8,
		mid_pkg::OP_LD_B_DIRECT_ADDRESS_8, mid_pkg::OP_LD_B_WDISP, mid_pkg::OP_LD_W_DIRECT_ADDRESS_8,
		mid_pkg::OP_LD_D_DIRECT_ADDRESS_8, mid_pkg::OP_ST_B_DIRECT_ADDRESS_16};

	logic              ref_clk;     // core clock
	logic              rst_b;       // reset, active low
	logic              src_mode;    // mode select
	logic              fetch_valid; // byte offered
	logic [7:0]        fetch_byte;  // offered byte
	logic              fetch_ready; // byte taken
	logic              busy;        // instruction running
	logic              cmd_valid;   // command pulse
	mid_pkg::mid_cmd_t cmd;         // decoded command
	logic              not_ours;    // reject pulse
	mid_note_t         exp_q [$];   // expected results, oldest first
	int                error_cnt;   // mismatches
	int                n_compared;  // comparisons
	int                cyc;         // clock count
	int                last_take;   // cycle of the last byte taken

	mid_move_decoder DUT (
		.ref_clk(ref_clk), .rst_b(rst_b), .src_mode(src_mode),
		.fetch_valid(fetch_valid), .fetch_byte(fetch_byte),
		.fetch_ready(fetch_ready), .busy(busy), .cmd_valid(cmd_valid),
		.cmd(cmd), .not_ours(not_ours));

	mid_fetch_model u_fetch (
		.ref_clk(ref_clk), .fetch_ready(fetch_ready),
		.fetch_valid(fetch_valid), .fetch_byte(fetch_byte));

	////////////////////////////////////////////////////////////////////////
	// 10 mhz clock
	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// compare and count
	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// verdict and end of run
	task automatic finish_test;
		if (error_cnt == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// wait for idle, then queue one instruction and its expectation
	task automatic run(input logic src, input logic [31:0] body, input int nb,
		input mid_note_t nt);
		int i;
		i = 0;
		while ((exp_q.size() != 0 || busy !== 1'b0) && i < 300)
		begin
			@(posedge ref_clk);
			i++;
		end
		#5 src_mode = src;
		if (!src && !nt.rej)
			u_fetch.push(mid_pkg::ESC_PREFIX);
		for (i = 0; i < nb; i++)
			u_fetch.push(body[31 - 8 * i -: 8]);
		exp_q.push_back(nt);
	endtask

	////////////////////////////////////////////////////////////////////////
	// result monitor: oldest note against each pulse, plus timeout
	always @(posedge ref_clk)
	begin : mon
		mid_note_t nt;
		cyc++;
		if (cyc > 20000)
		begin
			error_cnt++;
			finish_test();
		end
		if (cmd_valid === 1'b1 || not_ours === 1'b1)
		begin
			if (exp_q.size() == 0)
				check("result count", 32'h1, 32'h0);
			else
			begin
				nt = exp_q.pop_front();
				check("reject", 32'(not_ours), 32'(nt.rej));
				check("gap", cyc - last_take, nt.rej ? 1 : nt.st + 1);
				check("busy", 32'(busy), 32'h0);
				check("ready", 32'(fetch_ready), 32'h1);
				if (!nt.rej)
				begin
					check("op", 32'(cmd.op), 32'(nt.op));
					check("store", 32'(cmd.store), 32'(nt.op inside {mid_pkg::OP_ST_B_DIRECT_ADDRESS_16,
						mid_pkg::OP_ST_W_DIRECT_ADDRESS_16, mid_pkg::OP_ST_D_DIRECT_ADDRESS_16}));
					check("reg", 32'(cmd.reg_sel), 32'(nt.rs));
					check("ptr", 32'(cmd.ptr_sel), 32'(nt.ps));
					check("states", 32'(cmd.states), 32'(nt.st));
					if (nt.ca)
						check("addr", 32'(cmd.addr), 32'(nt.ad));
				end
			end
		end
		if (fetch_valid === 1'b1 && fetch_ready === 1'b1)
			last_take = cyc;
	end

	////////////////////////////////////////////////////////////////////////
	// main sequence: rejects, then every form in both modes
	initial
	begin
		mid_note_t   nt;
		logic [3:0]  r;
		logic [3:0]  p;
		logic [15:0] a;
		logic [7:0]  a8;
		logic [31:0] body;
		int          nb;
		logic        s;
		src_mode   = 1'b0;
		rst_b      = 1'b0;
		error_cnt  = 0;
		n_compared = 0;
		cyc        = 0;
		last_take  = 0;
		void'($urandom(32'h3cce));
		repeat (3) @(posedge ref_clk);
		#5 rst_b = 1'b1;
		nt = '{1'b1, 1'b0, mid_pkg::OP_NONE, 4'h0, 4'h0, 24'h0, 4'h0};
		run(1'b0, {8'h7e, 24'h0}, 1, nt);
		run(1'b1, {8'ha5, 24'h0}, 1, nt);
		for (int rep = 0; rep < 2; rep++)
			for (int k = 0; k < 2; k++)
				for (int f = 0; f < 15; f++)
				begin
					s  = k[0];
					r  = 4'($urandom);
					p  = 4'($urandom);
					a  = 16'($urandom);
					a8 = (f == 9) ? mid_pkg::PORT_ADDR[a[1:0]] : {a[7:4], 4'h1};
					nt = '{1'b0, 1'b1, OPS[f], r, 4'h0, {8'h00, a}, BST[f] - {3'h0, s}};
					body = {OPC[f], r, NIB[f], a};
					nb = 4;
					case (KND[f])
						2'h1:
						begin
							body  = {OPC[f], p, NIB[f], r, 4'h0, 8'h00};
							nb    = 3;
							nt.ps = p;
							nt.ca = 1'b0;
						end
						2'h2:
						begin
							body  = {OPC[f], r, p, a};
							nt.ps = p;
						end
						2'h3:
						begin
							body  = {OPC[f], r, NIB[f], a8, 8'h00};
							nb    = 3;
							nt.ad = {16'h0000, a8};
						end
						default:
							nb = 4;
					endcase
					run(s, body, nb, nt);
				end
		// drain: last result seen and decoder back in idle
		while (exp_q.size() != 0 || busy !== 1'b0)
			@(posedge ref_clk);
		if (exp_q.size() != 0)
			check("pending", 32'(exp_q.size()), 32'h0);
		finish_test();
	end
endmodule // tb_move_instruction_decoder
`default_nettype wire
